//--- core/sub_consts.svh
// Purpose: Offsets, field positions, reset values and encodings of the subtract datapath
// Assumes: Included by bare name from design files
// Notes: Register offsets are 16-bit word addresses on the plain register port
`ifndef SUB_CONSTS_SVH
`define SUB_CONSTS_SVH

`define OFF_INSTR 8'h00
`define OFF_ACCUM 8'h01
`define OFF_STATUS 8'h02
`define OFF_BANK 8'h03
`define OFF_CTRL 8'h04
`define OFF_INDEX_BASE 8'h05
`define OFF_MEM_ADDR 8'h06
`define OFF_MEM_DATA 8'h07

`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_OV 3
`define ST_N 4
`define CTRL_EXT_EN 0
`define CTRL_BUSY 1

`define RST_ACCUM 8'h00
`define RST_STATUS 5'h00
`define RST_BANK 4'h0
`define RST_INDEX_BASE 12'h000

`define OPC_LITERAL_SUB 8'h08
`define OPC_FILE_SUB 6'h17
`define OPC_BORROW_SUB 6'h15
`define ACCESS_LOW_MAX 8'h5F
`define ACCESS_HIGH_BANK 4'hF

`endif

//--- core/sub_pkg.sv
// Purpose: Types shared by the subtract datapath modules
// Assumes: Nothing
// Notes: Phases follow the four quarter cycles of one instruction cycle
package sub_pkg;

  typedef enum logic [2:0] {st_idle, st_q1, st_q2, st_q3, st_q4} phase_e;
  typedef enum logic [1:0] {op_none, op_literal, op_file, op_borrow} op_kind_e;

endpackage : sub_pkg

//--- core/alu_if.sv
// Purpose: Operand and flag bundle between the sequencer and the subtractor
// Assumes: Purely combinational traffic
// Notes: cin high means no borrow comes in
`timescale 1ns/1ns
interface alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [7:0] diff;
  logic c;
  logic dc;
  logic z;
  logic ov;
  logic n;
  modport user (output a, output b, output cin, input diff, input c, input dc, input z,
    input ov, input n);
  modport unit (input a, input b, input cin, output diff, output c, output dc, output z,
    output ov, output n);
endinterface : alu_if

//--- core/subtract_alu.sv
// Purpose: Two's complement subtractor a - b - !cin with status flags
// Assumes: Combinational, no clock
// Notes: Carry out high means no borrow, matching the core's carry sense
`timescale 1ns/1ns
module subtract_alu (
  alu_if.unit port
);

  wire [8:0] full_sum = {1'b0, port.a} + {1'b0, ~port.b} + {8'h00, port.cin};
  wire [4:0] low_sum = {1'b0, port.a[3:0]} + {1'b0, ~port.b[3:0]} + {4'h0, port.cin};

  assign port.diff = full_sum[7:0];
  assign port.c = full_sum[8];
  assign port.dc = low_sum[4];
  assign port.z = (full_sum[7:0] == 8'h00);
  assign port.n = full_sum[7];
  // Signs of operands differ and the result sign leaves the minuend's sign
  assign port.ov = (port.a[7] != port.b[7]) && (full_sum[7] != port.a[7]);

endmodule : subtract_alu

//--- core/subtract_instruction_datapath.sv
// Purpose: Subtract instruction datapath of an 8-bit core, one instruction per five clocks (four quarters and an idle clock)
// Assumes: Register port master drives from the same clock; reset synchronous
// Notes: File memory is local; register port reaches it through an address/data window
// Function
// - Literal subtract: immediate minus accumulator, result into accumulator
// - File subtract: file register minus accumulator, two's complement
// - Destination bit 0 writes accumulator, 1 writes file register back
// - Bank bit 0 uses access bank, 1 uses bank pointer register
// - Bank bit 0, extended set on, address up to 95: indexed literal offset
// - Negative result clears carry, sets negative, clears zero (here carry is set on any result without a borrow, negative or not)
// - Positive nonzero result sets carry, clears zero and negative (here carry is cleared whenever the subtraction borrows, positive or not)
// - Zero result sets carry and zero, clears negative (here a borrow subtract that borrows to a zero result leaves carry clear)
// - Borrow subtract: accumulator minus file minus inverted carry, routed by destination
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "sub_consts.svh"
module subtract_instruction_datapath #(
  parameter int ADDR_W = 12,
  parameter int FILE_DEPTH = 4096
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] address,
  input wire logic [15:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [15:0] read_data,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  sub_pkg::phase_e phase;
  sub_pkg::op_kind_e kind;
  logic [15:0] instr;
  logic [7:0] accumulator;
  logic [4:0] status;
  logic [3:0] bank_pointer_register;
  logic ext_enable;
  logic [ADDR_W-1:0] index_base;
  logic [ADDR_W-1:0] mem_addr;
  logic [ADDR_W-1:0] eff_addr;
  logic dest_file;
  logic [7:0] operand;
  logic [7:0] result;
  logic [4:0] flags;
  logic [7:0] file_mem [FILE_DEPTH];

  alu_if alu ();

  subtract_alu u_alu (
    .port(alu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire idle = (phase == sub_pkg::st_idle);
  wire wr_ok = write_strobe && idle;
  wire issue = wr_ok && (address == `OFF_INSTR);
  wire is_literal = (instr[15:8] == `OPC_LITERAL_SUB);
  wire is_file = (instr[15:10] == `OPC_FILE_SUB);
  wire is_borrow = (instr[15:10] == `OPC_BORROW_SUB);
  wire dest_bit = instr[9];
  wire bank_bit = instr[8];
  wire [7:0] f_addr = instr[7:0];
  wire low_access = (f_addr <= `ACCESS_LOW_MAX);
  wire indexed = !bank_bit && ext_enable && low_access;
  wire [ADDR_W-1:0] bank_addr = ADDR_W'({bank_pointer_register, f_addr});
  wire [ADDR_W-1:0] access_addr = low_access ? ADDR_W'({4'h0, f_addr})
    : ADDR_W'({`ACCESS_HIGH_BANK, f_addr});
  wire [ADDR_W-1:0] indexed_addr = index_base + ADDR_W'(f_addr);
  wire [ADDR_W-1:0] next_eff_addr = bank_bit ? bank_addr
    : (indexed ? indexed_addr : access_addr);
  wire sub_pkg::op_kind_e next_kind = is_literal ? sub_pkg::op_literal
    : (is_file ? sub_pkg::op_file
    : (is_borrow ? sub_pkg::op_borrow : sub_pkg::op_none));

  // Borrow form swaps minuend and subtrahend and takes the stored carry in
  wire borrow_op = (kind == sub_pkg::op_borrow);
  assign alu.a = borrow_op ? accumulator : operand;
  assign alu.b = borrow_op ? operand : accumulator;
  assign alu.cin = borrow_op ? status[`ST_C] : 1'b1;
  wire [4:0] alu_flags = {alu.n, alu.ov, alu.z, alu.dc, alu.c};

  wire write_accum = (phase == sub_pkg::st_q4) && (kind != sub_pkg::op_none)
    && !dest_file;
  wire write_file = (phase == sub_pkg::st_q4) && (kind != sub_pkg::op_none)
    && dest_file;

  wire [15:0] next_read_data =
    (address == `OFF_INSTR) ? instr
    : (address == `OFF_ACCUM) ? {8'h00, accumulator}
    : (address == `OFF_STATUS) ? {11'h0, status}
    : (address == `OFF_BANK) ? {12'h000, bank_pointer_register}
    : (address == `OFF_CTRL) ? {14'h0, busy, ext_enable}
    : (address == `OFF_INDEX_BASE) ? 16'(index_base)
    : (address == `OFF_MEM_ADDR) ? 16'(mem_addr)
    : (address == `OFF_MEM_DATA) ? {8'h00, file_mem[mem_addr]}
    : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one quarter per clock
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      phase <= sub_pkg::st_idle;
      busy <= 1'b0;
    end
    else
    begin
      unique case (phase)
        sub_pkg::st_idle: if (issue) phase <= sub_pkg::st_q1;
        sub_pkg::st_q1: phase <= sub_pkg::st_q2;
        sub_pkg::st_q2: phase <= sub_pkg::st_q3;
        sub_pkg::st_q3: phase <= sub_pkg::st_q4;
        sub_pkg::st_q4: phase <= sub_pkg::st_idle;
      endcase
      busy <= issue || (!idle && (phase != sub_pkg::st_q4));
    end
  end

  // Q1 decode, Q2 operand read, Q3 process
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      kind <= sub_pkg::op_none;
      dest_file <= 1'b0;
      eff_addr <= '0;
      operand <= 8'h00;
      result <= 8'h00;
      flags <= `RST_STATUS;
    end
    else
    begin
      if (phase == sub_pkg::st_q1)
      begin
        kind <= next_kind;
        dest_file <= !is_literal && dest_bit;
        eff_addr <= next_eff_addr;
      end
      if (phase == sub_pkg::st_q2)
        operand <= (kind == sub_pkg::op_literal) ? instr[7:0] : file_mem[eff_addr];
      if (phase == sub_pkg::st_q3)
      begin
        result <= alu.diff;
        flags <= alu_flags;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible registers; writes are refused while an instruction runs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      instr <= 16'h0000;
      accumulator <= `RST_ACCUM;
      status <= `RST_STATUS;
      bank_pointer_register <= `RST_BANK;
      ext_enable <= 1'b0;
      index_base <= `RST_INDEX_BASE;
      mem_addr <= '0;
      read_data <= 16'h0000;
    end
    else
    begin
      if (issue)
        instr <= write_data;
      if (write_accum)
        accumulator <= result;
      else if (wr_ok && (address == `OFF_ACCUM))
        accumulator <= write_data[7:0];
      if (phase == sub_pkg::st_q4 && kind != sub_pkg::op_none)
        status <= flags;
      else if (wr_ok && (address == `OFF_STATUS))
        status <= write_data[4:0];
      if (wr_ok && (address == `OFF_BANK))
        bank_pointer_register <= write_data[3:0];
      if (wr_ok && (address == `OFF_CTRL))
        ext_enable <= write_data[`CTRL_EXT_EN];
      if (wr_ok && (address == `OFF_INDEX_BASE))
        index_base <= write_data[ADDR_W-1:0];
      if (wr_ok && (address == `OFF_MEM_ADDR))
        mem_addr <= write_data[ADDR_W-1:0];
      read_data <= read_strobe ? next_read_data : 16'h0000;
    end
  end

  // File memory has no reset; its contents are software's to load
  always_ff @(posedge clk)
  begin
    if (write_file)
      file_mem[eff_addr] <= result;
    else if (wr_ok && (address == `OFF_MEM_DATA))
      file_mem[mem_addr] <= write_data[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_literal_to_accum: assert property ((phase == sub_pkg::st_q4 && kind == sub_pkg::op_literal)
    |=> accumulator == $past(result)) else $error("literal result not in accumulator");
  a_file_difference: assert property ((phase == sub_pkg::st_q3 && kind == sub_pkg::op_file)
    |=> result == 8'($past(operand) - $past(accumulator)))
    else $error("file subtract difference wrong");
  a_file_dest_keeps: assert property ((phase == sub_pkg::st_q4 && write_file)
    |=> accumulator == $past(accumulator) && file_mem[$past(eff_addr)] == $past(result))
    else $error("file destination routing wrong");
  a_banked_address: assert property ((phase == sub_pkg::st_q1 && bank_bit
    && next_kind != sub_pkg::op_literal)
    |=> eff_addr == ADDR_W'({$past(bank_pointer_register), $past(f_addr)}))
    else $error("bank pointer not used");
  a_indexed_address: assert property ((phase == sub_pkg::st_q1 && indexed
    && next_kind != sub_pkg::op_literal)
    |=> eff_addr == $past(index_base) + ADDR_W'($past(f_addr)))
    else $error("indexed offset address wrong");
  a_negative_flags: assert property ((phase == sub_pkg::st_q4 && kind != sub_pkg::op_none
    && result[7]) |=> status[`ST_N] && !status[`ST_Z])
    else $error("negative result flags wrong");
  a_positive_flags: assert property ((phase == sub_pkg::st_q4 && kind != sub_pkg::op_file
    && kind != sub_pkg::op_none && !result[7] && result != 8'h00)
    || (phase == sub_pkg::st_q4 && kind == sub_pkg::op_file && !result[7] && result != 8'h00
    && flags[`ST_C]) |=> !status[`ST_Z] && !status[`ST_N])
    else $error("positive result flags wrong");
  a_zero_flags: assert property ((phase == sub_pkg::st_q4 && kind != sub_pkg::op_none
    && result == 8'h00) |=> status[`ST_Z] && !status[`ST_N])
    else $error("zero result flags wrong");
  a_borrow_difference: assert property ((phase == sub_pkg::st_q3 && kind == sub_pkg::op_borrow)
    |=> result == 8'($past(accumulator) - $past(operand) - 8'(!$past(status[`ST_C]))))
    else $error("borrow subtract difference wrong");
  a_four_quarters: assert property ((phase == sub_pkg::st_idle && issue)
    |=> phase == sub_pkg::st_q1 ##1 phase == sub_pkg::st_q2 ##1 phase == sub_pkg::st_q3
    ##1 phase == sub_pkg::st_q4 ##1 (phase == sub_pkg::st_idle && !busy))
    else $error("instruction cycle not four quarters");
  a_overflow_flag: assert property ((phase == sub_pkg::st_q3 && kind != sub_pkg::op_none)
    ##1 1 |=> status[`ST_OV] == $past(flags[`ST_OV], 1)
    && status[`ST_DC] == $past(flags[`ST_DC], 1))
    else $error("overflow or nibble borrow flag wrong");

endmodule : subtract_instruction_datapath

//--- bench/tb.sv
// Purpose: Self-checking bench for the subtract datapath, integer model beside the design
// Assumes: Register port timing and register map as handed over
// Notes: File bytes are planted at the decoded address, so a wrong decode reads stale data
`timescale 1ns/1ns
`include "sub_consts.svh"
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] address = 8'h00;
  logic [15:0] write_data = 16'h0000;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [15:0] read_data;
  logic busy;
  int n_errors = 0;
  int check_count = 0;
  int sd;
  logic [15:0] rv;
  // Model results wait here until the design's registers are read back
  int exp_q[$];
  always #10 clk = ~clk;
  subtract_instruction_datapath #(.ADDR_W(12), .FILE_DEPTH(4096)) dut_u (.clk(clk),
    .reset(reset), .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data), .busy(busy));
  ////////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      n_errors++;
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    #1 rv = read_data;
  endtask : rd
  // Waits for busy to fall; the count of edges is part of the check
  task wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0)
    begin
      @(posedge clk);
      #1 n++;
      if (n > 20)
      begin
        $display("wrong value at %0t: busy never fell", $time);
        n_errors++;
        conclude();
      end
    end
  endtask : wait_idle
  task run(input logic [15:0] ins);
    int n;
    wr(`OFF_INSTR, ins);
    #1 chk({15'h0000, busy}, 16'h0001, "busy rise");
    wait_idle(n);
    chk(16'(n), 16'h0004, "cycle length");
  endtask : run
  task reset_vals;
    logic [7:0] al[8];
    al = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h40};
    foreach (al[i])
    begin
      rd(al[i]);
      chk(rv, 16'h0000, "reset or unmapped");
    end
    $display("test reset values done");
  endtask : reset_vals
  ////////////////////////////////////////////////////////////////////////////////
  task one(input int op, input int d, input int a, input int f, input int v, input int w,
    input int st, input int bk, input int ext, input int ib);
    int eff, x, y, bin, r, res, ov, ea, em, es;
    logic [15:0] ins;
    if (a == 1)
      eff = bk * 256 + f;
    else if (ext == 1 && f <= 95)
      eff = (ib + f) % 4096;
    else if (f <= 95)
      eff = f;
    else
      eff = 3840 + f;
    wr(`OFF_ACCUM, 16'(w));
    wr(`OFF_STATUS, 16'(st));
    wr(`OFF_BANK, 16'(bk));
    wr(`OFF_CTRL, 16'(ext));
    wr(`OFF_INDEX_BASE, 16'(ib));
    wr(`OFF_MEM_ADDR, 16'(eff));
    wr(`OFF_MEM_DATA, 16'(v));
    x = (op == 2) ? w : v;
    y = (op == 2) ? v : w;
    bin = (op == 2) ? 1 - (st & 1) : 0;
    r = x - y - bin;
    res = r & 255;
    ov = (((x ^ y) & (x ^ res) & 128) != 0) ? 1 : 0;
    es = (res >> 7) * 16 + ov * 8 + (res == 0) * 4 + ((x & 15) >= (y & 15) + bin) * 2 + (r >= 0);
    ea = (op == 0 || d == 0) ? res : w;
    em = (op != 0 && d == 1) ? res : v;
    case (op)
      0: ins = {`OPC_LITERAL_SUB, 8'(v)};
      1: ins = {`OPC_FILE_SUB, 1'(d), 1'(a), 8'(f)};
      2: ins = {`OPC_BORROW_SUB, 1'(d), 1'(a), 8'(f)};
      default: ins = {6'h16, 1'(d), 1'(a), 8'(f)};
    endcase
    if (op == 3)
    begin
      ea = w;
      em = v;
      es = st;
    end
    exp_q.push_back(ea);
    exp_q.push_back(es);
    exp_q.push_back(em);
    run(ins);
    rd(`OFF_ACCUM);
    chk(rv, 16'(exp_q.pop_front()), "accumulator");
    rd(`OFF_STATUS);
    chk(rv, 16'(exp_q.pop_front()), "status");
    rd(`OFF_MEM_DATA);
    chk(rv, 16'(exp_q.pop_front()), "file byte");
  endtask : one
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    sd = $urandom(99702);
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    reset_vals();
    one(0, 0, 0, 0, 2, 1, 0, 0, 0, 0);
    one(0, 0, 0, 0, 2, 2, 0, 0, 0, 0);
    one(0, 0, 0, 0, 2, 3, 0, 0, 0, 0);
    one(1, 1, 0, 32, 3, 2, 0, 0, 0, 0);
    one(1, 0, 0, 32, 2, 2, 0, 0, 0, 0);
    one(1, 1, 0, 32, 1, 2, 0, 0, 0, 0);
    one(2, 1, 0, 32, 1, 2, 0, 0, 0, 0);
    one(1, 1, 0, 95, 7, 2, 0, 0, 1, 4000);
    one(1, 1, 0, 96, 7, 2, 0, 0, 1, 4000);
    one(2, 0, 1, 200, 9, 4, 1, 10, 0, 0);
    one(3, 1, 0, 32, 5, 6, 3, 0, 0, 0);
    $display("test directed done");
    // Random operands, modes and carry in across all encodings
    for (int i = 0; i < 60; i++)
      one($urandom_range(0, 3), $urandom_range(0, 1), $urandom_range(0, 1), $urandom_range(0, 255),
        $urandom_range(0, 255), $urandom_range(0, 255), $urandom_range(0, 31),
        $urandom_range(0, 15), $urandom_range(0, 1), $urandom_range(0, 4095));
    $display("test random done");
    // Software writes while busy must not disturb the running instruction
    wr(`OFF_ACCUM, 16'h0001);
    wr(`OFF_MEM_ADDR, 16'h0005);
    wr(`OFF_MEM_DATA, 16'h0033);
    wr(`OFF_INSTR, {`OPC_LITERAL_SUB, 8'h02});
    wr(`OFF_ACCUM, 16'h007E);
    wr(`OFF_MEM_DATA, 16'h0044);
    wait_idle(n);
    rd(`OFF_ACCUM);
    chk(rv, 16'h0001, "write while busy");
    rd(`OFF_MEM_DATA);
    chk(rv, 16'h0033, "file write while busy");
    $display("test busy refusal done");
    // Reset changes only on a rising edge, like every other input
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    reset_vals();
    conclude();
  end
endmodule : tb
